/* rms_params.svh */
// Timing counts, frequency limits, divider width and reset values for the reference monitor and switchover block.
// Assumes a 100 MHz system clock; the cycle counts below are derived from that period.
`ifndef RMS_PARAMS_SVH
`define RMS_PARAMS_SVH

// System clock period in nanoseconds.
`define RMS_CLK_PERIOD_NS 10
// Feedback edges without a monitored edge before a missing alarm is raised.
`define RMS_MISS_EDGES 3
// Time raw lock must hold before the lock flag is shown, in nanoseconds.
`define RMS_LOCK_STABLE_NS 100000
`define RMS_LOCK_STABLE_CYC ((`RMS_LOCK_STABLE_NS + `RMS_CLK_PERIOD_NS - 1) / `RMS_CLK_PERIOD_NS)
// Spacing between two period extensions while slewing, in nanoseconds.
`define RMS_PSL_STEP_NS 1000
`define RMS_PSL_STEP_CYC ((`RMS_PSL_STEP_NS + `RMS_CLK_PERIOD_NS - 1) / `RMS_CLK_PERIOD_NS)
// Highest reference and highest upper detector frequency, in MHz.
`define RMS_REF_MAX_MHZ 710
`define RMS_PFD_MAX_MHZ 100
`define RMS_UPPER_PREDIV_MIN ((`RMS_REF_MAX_MHZ + `RMS_PFD_MAX_MHZ - 1) / `RMS_PFD_MAX_MHZ)
// Divider width for the pre-dividers and the lower loop feedback divider.
`define RMS_DIV_W 17
// Reset value of the selected reference.
`define RMS_ACTIVE_RST 1'b0

`endif

/* rms_pkg.sv */
// Types shared by the reference monitor and switchover block.
// Assumes rms_params.svh is compiled alongside.
package rms_pkg;

    // Loop operating mode.
    typedef enum logic [1:0] {
        RMS_OP_SYNTH = 2'h0,
        RMS_OP_HIGH_BW = 2'h1,
        RMS_OP_LOW_BW = 2'h2,
        RMS_OP_RSVD = 2'h3
    } rms_op_mode_t;

    // Reference switching mode.
    typedef enum logic [1:0] {
        RMS_SW_MAN_PIN = 2'h0,
        RMS_SW_MAN_REG = 2'h1,
        RMS_SW_AUTO_REV = 2'h2,
        RMS_SW_AUTO_NONREV = 2'h3
    } rms_switch_mode_t;

    // Reference selection state.
    typedef enum logic [1:0] {
        RMS_ST_ACQUIRE = 2'h0,
        RMS_ST_TRACK = 2'h1,
        RMS_ST_HOLDOVER = 2'h2
    } rms_sel_state_t;

endpackage

/* rms_miss_det.sv */
// Missing-edge detector: counts feedback edges since the last monitored edge.
// Assumes both edge inputs are one-cycle pulses already synchronised to clk_in.
`include "rms_params.svh"

module rms_miss_det #(
    parameter int MISS_EDGES = `RMS_MISS_EDGES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic mon_edge_in,
    input wire logic fb_edge_in,
    output logic alarm_out
);

    // Feedback edges seen since the last monitored edge, saturating.
    logic [3:0] count_q;
    logic [3:0] count_d;
    // Registered alarm level.
    logic alarm_q;
    logic alarm_d;

    // A monitored edge clears at once and wins over a feedback edge in the same cycle.
    always_comb begin
        count_d = count_q;
        alarm_d = alarm_q;
        if (mon_edge_in) begin
            count_d = 4'h0;
            alarm_d = 1'b0;
        end else if (fb_edge_in) begin
            if (count_q < 4'(MISS_EDGES)) begin
                count_d = count_q + 4'h1;
            end
            if (count_q >= 4'(MISS_EDGES - 1)) begin
                alarm_d = 1'b1;
            end
        end
    end

    // State registers.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_q <= 4'h0;
            alarm_q <= 1'b0;
        end else begin
            count_q <= count_d;
            alarm_q <= alarm_d;
        end
    end

    assign alarm_out = alarm_q;

    // The last of the missing feedback edges raises the alarm on the next edge.
    property p_miss_raise;
        @(posedge clk_in) disable iff (!rst_n_in)
        (fb_edge_in && !mon_edge_in && count_q == 4'(MISS_EDGES - 1)) |=> alarm_out;
    endproperty
    a_miss_raise: assert property (p_miss_raise) else $error("missing alarm not raised");

    // Any monitored edge drops the alarm on the next edge.
    property p_miss_clear;
        @(posedge clk_in) disable iff (!rst_n_in)
        mon_edge_in |=> !alarm_out;
    endproperty
    a_miss_clear: assert property (p_miss_clear) else $error("missing alarm not cleared");

endmodule

/* rms_ref_switch.sv */
// Reference monitor and switchover: missing-edge alarms, lock, selection, holdover and slewing.
// Assumes all clock and strobe pins are asynchronous to clk_in and far slower than it,
// and that the analog loop reports raw lock and phase alignment as levels.
`include "rms_params.svh"

module rms_ref_switch
    import rms_pkg::*;
#(
    parameter int LOCK_STABLE_CYC = `RMS_LOCK_STABLE_CYC,
    parameter int PSL_STEP_CYC = `RMS_PSL_STEP_CYC,
    parameter int DIV_W = `RMS_DIV_W
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic reference_0_in,
    input wire logic reference_1_in,
    input wire logic crystal_in,
    input wire logic upper_fb_in,
    input wire logic lower_fb_in,
    input wire logic [1:0] op_mode_in,
    input wire logic [1:0] switch_mode_field_in,
    input wire logic ref_sel_reg_in,
    input wire logic ref_sel_pin_in,
    input wire logic loop_lock_raw_in,
    input wire logic phase_aligned_in,
    input wire logic [DIV_W-1:0] upper_prediv_in,
    input wire logic [DIV_W-1:0] lower_prediv_in,
    input wire logic [DIV_W-1:0] low_loop_feedback_divider_in,
    output logic crystal_missing_alarm_out,
    output logic ref0_missing_alarm_out,
    output logic ref1_missing_alarm_out,
    output logic pll_locked_flag_out,
    output logic active_ref_out,
    output logic holdover_out,
    output logic freerun_out,
    output logic phase_adjust_en_out,
    output logic slew_active_out,
    output logic slew_extend_out,
    output logic [DIV_W-1:0] upper_prediv_out,
    output logic [DIV_W-1:0] lower_prediv_out,
    output logic [DIV_W-1:0] lower_fb_div_out
);

    // Pin bits in the synchroniser: clocks, select pin, lock and alignment levels.
    localparam int NSYNC = 8;
    localparam int S_REF0 = 0;
    localparam int S_REF1 = 1;
    localparam int S_XTAL = 2;
    localparam int S_FBUP = 3;
    localparam int S_FBLO = 4;
    localparam int S_SELP = 5;
    localparam int S_LOCK = 6;
    localparam int S_ALGN = 7;

    // Two-flop synchroniser and a third stage for edge detection.
    logic [NSYNC-1:0] meta_q;
    logic [NSYNC-1:0] sync_q;
    logic [NSYNC-1:0] prev_q;
    logic [NSYNC-1:0] pins;
    // Rising edges of the synchronised clock pins.
    logic [NSYNC-1:0] rise;
    // Feedback edge used for reference monitoring.
    logic ref_fb_edge;
    logic xtal_bad;
    logic ref0_bad;
    logic ref1_bad;
    logic [1:0] ref_ok;
    rms_op_mode_t op_mode;
    rms_switch_mode_t sw_mode;
    logic manual;
    logic man_sel;

    assign pins = {phase_aligned_in, loop_lock_raw_in, ref_sel_pin_in, lower_fb_in,
                   upper_fb_in, crystal_in, reference_1_in, reference_0_in};

    // Every pin passes two flops; the second stage and its delayed copy feed logic.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= 8'h00;
            sync_q <= 8'h00;
            prev_q <= 8'h00;
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign rise = sync_q & ~prev_q;
    assign op_mode = rms_op_mode_t'(op_mode_in);
    assign sw_mode = rms_switch_mode_t'(switch_mode_field_in);
    assign manual = (sw_mode == RMS_SW_MAN_PIN) || (sw_mode == RMS_SW_MAN_REG);
    // Pin select only in manual-by-pin; every other mode takes the register bit.
    assign man_sel = (sw_mode == RMS_SW_MAN_PIN) ? sync_q[S_SELP] : ref_sel_reg_in;

    // Low band compares against the lower detector, all else against the upper.
    assign ref_fb_edge = (op_mode == RMS_OP_LOW_BW) ? rise[S_FBLO] : rise[S_FBUP];

    // Crystal is always checked at the upper detector.
    rms_miss_det u_xtal_det (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .mon_edge_in(rise[S_XTAL]),
        .fb_edge_in(rise[S_FBUP]),
        .alarm_out(xtal_bad)
    );

    rms_miss_det u_ref0_det (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .mon_edge_in(rise[S_REF0]),
        .fb_edge_in(ref_fb_edge),
        .alarm_out(ref0_bad)
    );

    rms_miss_det u_ref1_det (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .mon_edge_in(rise[S_REF1]),
        .fb_edge_in(ref_fb_edge),
        .alarm_out(ref1_bad)
    );

    assign ref_ok = {~ref1_bad, ~ref0_bad};

    // Selection state, active reference and the switch strobe.
    rms_sel_state_t state_q;
    rms_sel_state_t state_d;
    logic active_q;
    logic active_d;
    logic switched;
    // Stable-lock counter and flag; the count restarts on every reference switch.
    logic [15:0] lock_cnt_q;
    logic [15:0] lock_cnt_d;
    logic stable_q;
    logic stable_d;

    // Selection: manual follows the user only, automatic follows validity and preference.
    always_comb begin
        state_d = state_q;
        active_d = active_q;
        if (manual) begin
            // A bad selection holds over even if the other input is good.
            if (!ref_ok[man_sel]) begin
                state_d = RMS_ST_HOLDOVER;
            end else begin
                active_d = man_sel;
                // A valid selection is tracked at once, out of reset as out of holdover,
                // so the lock flag can show in manual mode without a holdover round first.
                state_d = RMS_ST_TRACK;
            end
        end else begin
            unique case (state_q)
                // Unlocked: only the preferred input is considered, to avoid hunting.
                RMS_ST_ACQUIRE: begin
                    active_d = ref_sel_reg_in;
                    if (!ref_ok[0] && !ref_ok[1]) begin
                        state_d = RMS_ST_HOLDOVER;
                    end else if (stable_q && ref_ok[ref_sel_reg_in]) begin
                        state_d = RMS_ST_TRACK;
                    end
                end
                RMS_ST_TRACK: begin
                    if (ref_ok[active_q]) begin
                        // Revertive goes home once the preferred input is back.
                        if (sw_mode == RMS_SW_AUTO_REV && ref_ok[ref_sel_reg_in]) begin
                            active_d = ref_sel_reg_in;
                        end
                    end else if (ref_ok[~active_q]) begin
                        active_d = ~active_q;
                    end else begin
                        state_d = RMS_ST_HOLDOVER;
                    end
                end
                // Whichever input turns valid first; both valid picks the preferred.
                RMS_ST_HOLDOVER: begin
                    if (ref_ok[0] && ref_ok[1]) begin
                        active_d = ref_sel_reg_in;
                        state_d = RMS_ST_TRACK;
                    end else if (ref_ok[0] || ref_ok[1]) begin
                        active_d = ref_ok[1];
                        state_d = RMS_ST_TRACK;
                    end
                end
                default: begin
                    state_d = RMS_ST_ACQUIRE;
                end
            endcase
        end
    end

    // Returning from holdover counts as a switch, so it slews too.
    assign switched = (active_d != active_q) ||
                      (state_q == RMS_ST_HOLDOVER && state_d == RMS_ST_TRACK);

    // Stable lock needs raw lock held for the whole interval on one reference.
    always_comb begin
        lock_cnt_d = lock_cnt_q;
        stable_d = stable_q;
        if (!sync_q[S_LOCK] || switched) begin
            lock_cnt_d = 16'h0000;
            stable_d = 1'b0;
        end else if (lock_cnt_q < 16'(LOCK_STABLE_CYC - 1)) begin
            lock_cnt_d = lock_cnt_q + 16'h0001;
        end else begin
            stable_d = 1'b1;
        end
    end

    // Selection and lock registers.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= RMS_ST_ACQUIRE;
            active_q <= `RMS_ACTIVE_RST;
            lock_cnt_q <= 16'h0000;
            stable_q <= 1'b0;
        end else begin
            state_q <= state_d;
            active_q <= active_d;
            lock_cnt_q <= lock_cnt_d;
            stable_q <= stable_d;
        end
    end

    // Phase slope limiting: one period extension per step until the loop reports alignment.
    // There is deliberately no shortening strobe, so no short output period can appear.
    logic slew_q;
    logic slew_d;
    logic [15:0] step_q;
    logic [15:0] step_d;
    logic extend_q;
    logic extend_d;

    always_comb begin
        slew_d = slew_q;
        step_d = step_q;
        extend_d = 1'b0;
        if (state_d == RMS_ST_HOLDOVER) begin
            // No reference, so phase is left alone.
            slew_d = 1'b0;
            step_d = 16'h0000;
        end else if (switched) begin
            slew_d = 1'b1;
            step_d = 16'h0000;
        end else if (slew_q) begin
            if (sync_q[S_ALGN]) begin
                slew_d = 1'b0;
            end else if (step_q == 16'(PSL_STEP_CYC - 1)) begin
                step_d = 16'h0000;
                extend_d = 1'b1;
            end else begin
                step_d = step_q + 16'h0001;
            end
        end
    end

    // Slew registers.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            slew_q <= 1'b0;
            step_q <= 16'h0000;
            extend_q <= 1'b0;
        end else begin
            slew_q <= slew_d;
            step_q <= step_d;
            extend_q <= extend_d;
        end
    end

    // Divider routing per mode; a too-small upper pre-divider is raised to the floor.
    logic [DIV_W-1:0] up_div_d;
    logic [DIV_W-1:0] lo_pre_d;
    logic [DIV_W-1:0] lo_fb_d;
    logic [DIV_W-1:0] up_div_q;
    logic [DIV_W-1:0] lo_pre_q;
    logic [DIV_W-1:0] lo_fb_q;

    always_comb begin
        up_div_d = DIV_W'(1);
        lo_pre_d = '0;
        lo_fb_d = '0;
        if (op_mode == RMS_OP_HIGH_BW) begin
            up_div_d = (upper_prediv_in < DIV_W'(`RMS_UPPER_PREDIV_MIN)) ?
                       DIV_W'(`RMS_UPPER_PREDIV_MIN) : upper_prediv_in;
        end else if (op_mode == RMS_OP_LOW_BW) begin
            // Zero would stop the lower detector, so it is treated as one.
            lo_pre_d = (lower_prediv_in == '0) ? DIV_W'(1) : lower_prediv_in;
            lo_fb_d = (low_loop_feedback_divider_in == '0) ? DIV_W'(1) :
                      low_loop_feedback_divider_in;
        end
    end

    // Divider registers.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            up_div_q <= DIV_W'(1);
            lo_pre_q <= '0;
            lo_fb_q <= '0;
        end else begin
            up_div_q <= up_div_d;
            lo_pre_q <= lo_pre_d;
            lo_fb_q <= lo_fb_d;
        end
    end

    // Synthesizer mode locks to the crystal; translators need a tracked reference.
    assign pll_locked_flag_out = stable_q && ((op_mode == RMS_OP_SYNTH) ? !xtal_bad :
                                 (state_q == RMS_ST_TRACK));
    assign crystal_missing_alarm_out = xtal_bad;
    assign ref0_missing_alarm_out = ref0_bad;
    assign ref1_missing_alarm_out = ref1_bad;
    assign active_ref_out = active_q;
    assign holdover_out = (state_q == RMS_ST_HOLDOVER);
    // Low band holds against the crystal; high band free-runs on the oscillator.
    assign freerun_out = holdover_out && (op_mode == RMS_OP_HIGH_BW);
    assign phase_adjust_en_out = !holdover_out;
    assign slew_active_out = slew_q;
    assign slew_extend_out = extend_q;
    assign upper_prediv_out = up_div_q;
    assign lower_prediv_out = lo_pre_q;
    assign lower_fb_div_out = lo_fb_q;

    // Loss of raw lock drops the flag on the next edge.
    property p_lock_drop;
        @(posedge clk_in) disable iff (!rst_n_in)
        !sync_q[S_LOCK] |=> !pll_locked_flag_out;
    endproperty
    a_lock_drop: assert property (p_lock_drop) else $error("lock flag outlived lock");

    // Manual mode with a bad selection is in holdover one edge later.
    property p_man_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
        (manual && !ref_ok[man_sel]) |=> holdover_out;
    endproperty
    a_man_hold: assert property (p_man_hold) else $error("manual holdover missed");

    // Automatic holdover is only ever entered with both references bad.
    property p_auto_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
        (!manual && !holdover_out && ref_ok != 2'h0 && $past(!manual)) |=> !holdover_out;
    endproperty
    a_auto_hold: assert property (p_auto_hold) else $error("auto holdover with a good ref");

    // Manual mode never changes reference while the selection is steady.
    property p_man_steady;
        @(posedge clk_in) disable iff (!rst_n_in)
        (manual && $stable(man_sel) && $stable(sw_mode) && active_q == man_sel) |=>
            $stable(active_q);
    endproperty
    a_man_steady: assert property (p_man_steady) else $error("manual self switch");

    // Revertive tracking returns to the valid preferred input in one edge.
    property p_revert;
        @(posedge clk_in) disable iff (!rst_n_in)
        (sw_mode == RMS_SW_AUTO_REV && state_q == RMS_ST_TRACK && ref_ok == 2'h3) |=>
            (active_q == $past(ref_sel_reg_in));
    endproperty
    a_revert: assert property (p_revert) else $error("revertive did not return");

    // Extensions come only while slewing and never twice in a row.
    property p_extend;
        @(posedge clk_in) disable iff (!rst_n_in)
        slew_extend_out |-> ($past(slew_q) && !$past(slew_extend_out));
    endproperty
    a_extend: assert property (p_extend) else $error("stray period extension");

    // In holdover no phase adjustment and no slewing take place.
    property p_hold_still;
        @(posedge clk_in) disable iff (!rst_n_in)
        holdover_out |-> (!phase_adjust_en_out && !slew_active_out);
    endproperty
    a_hold_still: assert property (p_hold_still) else $error("adjusting in holdover");

endmodule

/* rms_ref_src.sv */
// Model of the far side: reference 0, reference 1, the crystal and both feedback paths.
// Assumes the bench drives the enables at the falling edge of clk_in.
module rms_ref_src #(
    parameter int HALF = 8
) (
    input wire logic clk_in,
    input wire logic [4:0] en_in,
    output logic [4:0] clk_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // Bit 0 reference 0, 1 reference 1, 2 crystal, 3 upper feedback, 4 lower feedback.
    int cnt = 0;
    logic ph = 1'b0;
    // One shared phase keeps the sources slow, well under a quarter of clk_in.
    always @(negedge clk_in) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) begin
            ph <= !ph;
        end
    end
    // A disabled source stands still at low, as a failed oscillator would.
    assign clk_out = {5{ph}} & en_in;
endmodule

/* rms_ref_switch_tb.sv */
// Self-checking bench for the reference monitor and switchover block.
// Assumes rms_pkg and rms_params.svh are compiled first; counts are shortened.
`include "rms_params.svh"
`define RMS_CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module rms_ref_switch_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [4:0] en = 5'h1F;
    logic [4:0] src;
    logic [1:0] op_mode = 2'h1;
    logic [1:0] sw_mode = 2'h2;
    logic sel_reg = 1'b0;
    logic sel_pin = 1'b1;
    logic lock_raw = 1'b0;
    logic aligned = 1'b0;
    logic [16:0] up_pd = 17'h00002;
    logic [16:0] lo_pd = 17'h00000;
    logic [16:0] lo_fb = 17'h004D2;
    logic xa, r0a, r1a, lk, act, ho, fr, pa, sa, se;
    logic [16:0] up_o, lo_o, fb_o;
    int miscompares = 0;
    int n_tests = 0;
    // The clock toggles every half period of 5 ns.
    always #5 clk_in = !clk_in;
    rms_ref_src u_rms_ref_src (.clk_in(clk_in), .en_in(en), .clk_out(src));
    rms_ref_switch #(.LOCK_STABLE_CYC(20), .PSL_STEP_CYC(4)) u_rms_ref_switch (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .reference_0_in(src[0]),
        .reference_1_in(src[1]), .crystal_in(src[2]), .upper_fb_in(src[3]),
        .lower_fb_in(src[4]), .op_mode_in(op_mode), .switch_mode_field_in(sw_mode),
        .ref_sel_reg_in(sel_reg), .ref_sel_pin_in(sel_pin), .loop_lock_raw_in(lock_raw),
        .phase_aligned_in(aligned), .upper_prediv_in(up_pd), .lower_prediv_in(lo_pd),
        .low_loop_feedback_divider_in(lo_fb), .crystal_missing_alarm_out(xa),
        .ref0_missing_alarm_out(r0a), .ref1_missing_alarm_out(r1a),
        .pll_locked_flag_out(lk), .active_ref_out(act), .holdover_out(ho),
        .freerun_out(fr), .phase_adjust_en_out(pa), .slew_active_out(sa),
        .slew_extend_out(se), .upper_prediv_out(up_o), .lower_prediv_out(lo_o),
        .lower_fb_div_out(fb_o));
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Selects one of eight status outputs by number, so one wait task serves them all.
    function automatic logic pick(input int k);
        case (k)
            0: return xa;
            1: return r0a;
            2: return r1a;
            3: return lk;
            4: return act;
            5: return ho;
            6: return sa;
            default: return se;
        endcase
    endfunction
    // Waits a bounded number of cycles for an output to take a value; a hang ends the run.
    task automatic wt(input int k, input logic v, input string nm);
        int i;
        for (i = 0; i < 400 && pick(k) !== v; i++) begin
            @(negedge clk_in);
        end
        if (i == 400) begin
            miscompares++;
            $display("wrong value %s expected %0h seen timeout", nm, v);
            final_report();
        end else begin
            `RMS_CHK(nm, v, pick(k))
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    initial begin
        repeat (20) @(negedge clk_in);
        rst_n_in = 1'b1;
        idle(4);
        // Out of reset nothing is alarmed, locked or held over.
        `RMS_CHK("lock", 1'b0, lk)
        `RMS_CHK("holdover", 1'b0, ho)
        `RMS_CHK("phase adjust", 1'b1, pa)
        `RMS_CHK("upper prediv", 17'(`RMS_UPPER_PREDIV_MIN), up_o)
        $display("test reset done");
        // Missing-edge alarms in high band, against the upper feedback.
        en[2] = 1'b0;
        wt(0, 1'b1, "crystal alarm");
        en[2] = 1'b1;
        wt(0, 1'b0, "crystal alarm");
        en[0] = 1'b0;
        wt(1, 1'b1, "ref0 alarm");
        en[0] = 1'b1;
        wt(1, 1'b0, "ref0 alarm");
        // In low band only the lower feedback may count missing reference edges.
        op_mode = 2'h2;
        en[4] = 1'b0;
        en[1] = 1'b0;
        idle(150);
        `RMS_CHK("ref1 alarm", 1'b0, r1a)
        `RMS_CHK("lower prediv", 17'h00001, lo_o)
        `RMS_CHK("lower fb div", 17'h004D2, fb_o)
        en[4] = 1'b1;
        wt(2, 1'b1, "ref1 alarm");
        en[1] = 1'b1;
        wt(2, 1'b0, "ref1 alarm");
        op_mode = 2'h1;
        $display("test alarms done");
        // Automatic revertive: the pin says 1, the register bit prefers 0.
        lock_raw = 1'b1;
        wt(3, 1'b1, "lock");
        `RMS_CHK("active", 1'b0, act)
        en[0] = 1'b0;
        wt(4, 1'b1, "active");
        `RMS_CHK("slew active", 1'b1, sa)
        wt(3, 1'b0, "lock");
        wt(7, 1'b1, "slew extend");
        aligned = 1'b1;
        wt(6, 1'b0, "slew active");
        en[0] = 1'b1;
        wt(4, 1'b0, "active");
        $display("test revertive done");
        // Non-revertive stays on the other reference; then both fail.
        sw_mode = 2'h3;
        wt(3, 1'b1, "lock");
        en[0] = 1'b0;
        wt(4, 1'b1, "active");
        en[0] = 1'b1;
        idle(100);
        `RMS_CHK("active", 1'b1, act)
        en[1:0] = 2'h0;
        wt(5, 1'b1, "holdover");
        `RMS_CHK("phase adjust", 1'b0, pa)
        `RMS_CHK("freerun", 1'b1, fr)
        aligned = 1'b0;
        en[1] = 1'b1;
        wt(5, 1'b0, "holdover");
        `RMS_CHK("active", 1'b1, act)
        wt(6, 1'b1, "slew active");
        aligned = 1'b1;
        en[0] = 1'b1;
        $display("test nonrevertive done");
        // Manual by pin: a bad selection holds over although reference 1 is good.
        sw_mode = 2'h0;
        sel_pin = 1'b0;
        wt(4, 1'b0, "active");
        en[0] = 1'b0;
        wt(5, 1'b1, "holdover");
        idle(60);
        `RMS_CHK("active", 1'b0, act)
        en[0] = 1'b1;
        wt(5, 1'b0, "holdover");
        sel_pin = 1'b1;
        wt(4, 1'b1, "active");
        // Manual by register follows the bit and not the pin.
        sw_mode = 2'h1;
        wt(4, 1'b0, "active");
        $display("test manual done");
        // Lock returns on the selected reference once the stable count has run again.
        wt(3, 1'b1, "lock");
        // Synthesizer mode locks to the crystal, even with the selected reference lost to holdover.
        op_mode = 2'h0;
        en[0] = 1'b0;
        wt(5, 1'b1, "holdover");
        `RMS_CHK("lock", 1'b1, lk)
        `RMS_CHK("freerun", 1'b0, fr)
        // Low band holds over against the crystal instead of running free.
        op_mode = 2'h2;
        idle(2);
        `RMS_CHK("freerun", 1'b0, fr)
        `RMS_CHK("lock", 1'b0, lk)
        // Back in synthesizer mode a missing crystal takes the lock away.
        op_mode = 2'h0;
        en[2] = 1'b0;
        wt(3, 1'b0, "lock");
        en[2] = 1'b1;
        $display("test synth done");
        final_report();
    end
endmodule
